//--- rtl/fpc_flash_map.vh
// How it works
// - Launch needs 5 then A in upper nibble.
// - Latch space map bit routes data writes.
// - Busy bit is hardware owned, software-proof.
// - Flash control resets to zero.
// - 256 pages of 128 bytes, split address.
// - Programming erases loaded bytes first.
// - Busy lasts the 10 ms program time.
// - Code reads return a byte every cycle.
// - External access pin low fetches externally, except in security mode.
// - Speed bit clear selects six-clock mode.
// - Boot bit picks 0000h or F400h.
// - Oscillator range code 00 is refused.
// - Lock bits 2-0, bit 3 reserved.
// - Speed and boot bits software writable.
// - Mode field selects user, extra row, security.
// - CPU idles while programming runs.
`ifndef FPC_FLASH_MAP_VH
`define FPC_FLASH_MAP_VH

// ----------------------------------------------------------------
// Flash control register
// ----------------------------------------------------------------
`define FPC_FCTL_ADDR     8'hd1
`define FPC_FCTL_RESET    8'h00
`define FPC_LAUNCH_HI     7
`define FPC_LAUNCH_LO     4
`define FPC_MAP_BIT       3
`define FPC_MODE_HI       2
`define FPC_MODE_LO       1
`define FPC_BUSY_BIT      0
`define FPC_UNLOCK_CODE   4'h5
`define FPC_LAUNCH_CODE   4'ha
`define FPC_MODE_USER     2'h0
`define FPC_MODE_XROW     2'h1
`define FPC_MODE_SEC      2'h2
`define FPC_MODE_RSVD     2'h3

// ----------------------------------------------------------------
// Security byte
// ----------------------------------------------------------------
`define FPC_SEC_RESET     8'hb0
`define FPC_SEC_SPEED     7
`define FPC_SEC_BOOT      6
`define FPC_SEC_OSC_HI    5
`define FPC_SEC_OSC_LO    4
`define FPC_SEC_LOCK_HI   2
`define FPC_SEC_LOCK_LO   0
`define FPC_OSC_BAD       2'h0
`define FPC_BOOT_USER     16'h0000
`define FPC_BOOT_LOADER   16'hf400

// ----------------------------------------------------------------
// Array geometry and timing
// ----------------------------------------------------------------
`define FPC_PAGE_BITS     8
`define FPC_BYTE_BITS     7
`define FPC_XROW_PAGE     9'h1ff
`define FPC_PROG_TIME_US  10000
`define FPC_CLK_MHZ       125

`endif

//--- rtl/fpc_page_latch.v
`timescale 1ns/100ps
`include "fpc_flash_map.vh"

module fpc_page_latch #(
	parameter BW = `FPC_BYTE_BITS
) (
	input  wire          ref_clk,
	input  wire          rst,
	input  wire          loadEn,
	input  wire [BW-1:0] loadIdx,
	input  wire [7:0]    loadData,
	input  wire          clearAll,
	input  wire [BW-1:0] readIdx,
	output wire [7:0]    readData,
	output wire          readLoaded
);

	reg [7:0]        latchMem [0:(1<<BW)-1];
	reg [(1<<BW)-1:0] loaded_r;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Only loaded bytes are programmed, so a partial page is safe.
	always @(posedge ref_clk) begin
		if (loadEn) begin
			latchMem[loadIdx] <= loadData;
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			loaded_r <= {(1<<BW){1'b0}};
		end else if (clearAll) begin
			loaded_r <= {(1<<BW){1'b0}};
		end else if (loadEn) begin
			loaded_r[loadIdx] <= 1'b1;
		end
	end

	assign readData   = latchMem[readIdx];
	assign readLoaded = loaded_r[readIdx];

endmodule

//--- rtl/fpc_flash_array.v
`timescale 1ns/100ps
`include "fpc_flash_map.vh"

module fpc_flash_array #(
	parameter PW = `FPC_PAGE_BITS,
	parameter BW = `FPC_BYTE_BITS
) (
	input  wire             ref_clk,
	input  wire [PW+BW-1:0] rdAddr,
	input  wire             rdXrow,
	output wire [7:0]       rdData,
	input  wire             wrEn,
	input  wire             wrXrow,
	input  wire [PW+BW-1:0] wrAddr,
	input  wire [7:0]       wrData
);

	reg [7:0] userMem [0:(1<<(PW+BW))-1];
	reg [7:0] xrowMem [0:(1<<BW)-1];

	// ----------------------------------------------------------------
	// Cell model
	// ----------------------------------------------------------------
	// Read is combinational so the caller can register it with no stall.
	always @(posedge ref_clk) begin
		if (wrEn && wrXrow) begin
			xrowMem[wrAddr[BW-1:0]] <= wrData;
		end else if (wrEn) begin
			userMem[wrAddr] <= wrData;
		end
	end

	assign rdData = rdXrow ? xrowMem[rdAddr[BW-1:0]] : userMem[rdAddr];

endmodule

//--- rtl/fpc_flash_program_control.v
`timescale 1ns/100ps
`include "fpc_flash_map.vh"

module fpc_flash_program_control #(
	parameter PW         = `FPC_PAGE_BITS,
	parameter BW         = `FPC_BYTE_BITS,
	parameter CW         = 21,
	parameter PROG_CYCLES = `FPC_PROG_TIME_US * `FPC_CLK_MHZ
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire [7:0]  sfrAddr,
	input  wire        sfrWrite,
	input  wire        sfrRead,
	input  wire [7:0]  sfrWdata,
	output reg  [7:0]  sfrRdata_r,
	input  wire [15:0] xdataAddr,
	input  wire        xdataWrite,
	input  wire [7:0]  xdataWdata,
	output reg         latch_space_map_r,
	input  wire [15:0] codeAddr,
	output reg  [7:0]  codeData_r,
	output reg         externalFetch_r,
	input  wire        external_access_pin,
	input  wire        ppSecWrite,
	input  wire [7:0]  ppSecData,
	output reg         cpuIdleReq_r,
	output reg         double_speed_select_r,
	output reg  [15:0] bootVector_r,
	output reg  [1:0]  oscillator_range_r,
	output reg  [2:0]  lock_level_bits_r,
	output reg  [7:0]  nonvolatile_security_byte_r
);

	localparam [4:0] S_IDLE  = 5'h01;
	localparam [4:0] S_ERASE = 5'h02;
	localparam [4:0] S_WRITE = 5'h04;
	localparam [4:0] S_WAIT  = 5'h08;
	localparam [4:0] S_DONE  = 5'h10;
	localparam [CW-1:0] PROG_CNT = PROG_CYCLES[CW-1:0];
	localparam [BW-1:0] LAST_IDX = {BW{1'b1}};
	localparam [7:0]    FCTL_RST = `FPC_FCTL_RESET;

	reg  [3:0]       launch_code_nibble_r;
	reg  [1:0]       flash_space_select_r;
	reg              program_in_progress_r;
	reg              unlockArmed_r;
	reg  [4:0]       state_r;
	reg  [4:0]       state_nxt;
	reg  [CW-1:0]    timer_r;
	reg  [BW-1:0]    walkIdx_r;
	reg  [PW-1:0]    pageSel_r;
	reg              eaMeta_r;
	reg              eaSync_r;
	reg              bootTaken_r;
	wire [7:0]       latchData;
	wire             latchLoaded;
	wire [7:0]       arrayData;
	wire             fctlWrite;
	wire             launchReq;
	wire             latchLoad;
	wire             arrayWrEn;
	wire             rdXrow;
	wire [7:0]       fctlValue;
	wire [7:0]       secMerged;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function inXrow;
		input [15:0] addr;
		begin
			inXrow = (addr[15:BW] == `FPC_XROW_PAGE);
		end
	endfunction

	assign fctlWrite = sfrWrite && (sfrAddr == `FPC_FCTL_ADDR);
	// Mode 11 is reserved and the launch is swallowed.
	assign launchReq = fctlWrite && unlockArmed_r && !program_in_progress_r
		&& (sfrWdata[`FPC_LAUNCH_HI:`FPC_LAUNCH_LO] == `FPC_LAUNCH_CODE)
		&& (sfrWdata[`FPC_MODE_HI:`FPC_MODE_LO] != `FPC_MODE_RSVD);
	assign latchLoad = xdataWrite && latch_space_map_r
		&& !program_in_progress_r;
	assign fctlValue = {launch_code_nibble_r, latch_space_map_r,
		flash_space_select_r, program_in_progress_r};

	// ----------------------------------------------------------------
	// Flash control register
	// ----------------------------------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			launch_code_nibble_r <= FCTL_RST[`FPC_LAUNCH_HI:`FPC_LAUNCH_LO];
			latch_space_map_r    <= FCTL_RST[`FPC_MAP_BIT];
			flash_space_select_r <= FCTL_RST[`FPC_MODE_HI:`FPC_MODE_LO];
			unlockArmed_r        <= 1'b0;
		end else if (fctlWrite) begin
			launch_code_nibble_r <= sfrWdata[`FPC_LAUNCH_HI:`FPC_LAUNCH_LO];
			latch_space_map_r    <= sfrWdata[`FPC_MAP_BIT];
			flash_space_select_r <= sfrWdata[`FPC_MODE_HI:`FPC_MODE_LO];
			// Any write other than the unlock code drops the arming.
			unlockArmed_r <= (sfrWdata[`FPC_LAUNCH_HI:`FPC_LAUNCH_LO]
				== `FPC_UNLOCK_CODE);
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sfrRdata_r <= 8'h00;
		end else if (sfrRead && (sfrAddr == `FPC_FCTL_ADDR)) begin
			sfrRdata_r <= fctlValue;
		end else begin
			sfrRdata_r <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Page latch loading
	// ----------------------------------------------------------------
	// The last page address written picks the page to program.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pageSel_r <= {PW{1'b0}};
		end else if (latchLoad) begin
			pageSel_r <= xdataAddr[PW+BW-1:BW];
		end
	end

	fpc_page_latch #(
		.BW         (BW)
	) uLatch (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.loadEn     (latchLoad),
		.loadIdx    (xdataAddr[BW-1:0]),
		.loadData   (xdataWdata),
		.clearAll   (state_r == S_DONE),
		.readIdx    (walkIdx_r),
		.readData   (latchData),
		.readLoaded (latchLoaded)
	);

	// ----------------------------------------------------------------
	// Program sequencer
	// ----------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (launchReq) begin
					state_nxt = S_ERASE;
				end
			end
			S_ERASE: begin
				if (walkIdx_r == LAST_IDX) begin
					state_nxt = S_WRITE;
				end
			end
			S_WRITE: begin
				if (walkIdx_r == LAST_IDX) begin
					state_nxt = S_WAIT;
				end
			end
			S_WAIT: begin
				if (timer_r == {CW{1'b0}}) begin
					state_nxt = S_DONE;
				end
			end
			S_DONE: begin
				state_nxt = S_IDLE;
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r   <= S_IDLE;
			walkIdx_r <= {BW{1'b0}};
			timer_r   <= {CW{1'b0}};
		end else begin
			state_r <= state_nxt;
			if (state_r == S_ERASE || state_r == S_WRITE) begin
				walkIdx_r <= walkIdx_r + 1'b1;
			end else begin
				walkIdx_r <= {BW{1'b0}};
			end
			if (launchReq && state_r == S_IDLE) begin
				timer_r <= PROG_CNT - 1'b1;
			end else if (timer_r != {CW{1'b0}}) begin
				timer_r <= timer_r - 1'b1;
			end
		end
	end

	// Busy covers erase, program, wait and the latch clear cycle, so no
	// launch or latch load can slip into the clear; software has no path.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			program_in_progress_r <= 1'b0;
			cpuIdleReq_r          <= 1'b0;
		end else begin
			program_in_progress_r <= (state_nxt != S_IDLE);
			cpuIdleReq_r <= (state_nxt != S_IDLE);
		end
	end

	// Erase writes ones to each loaded byte, then the data follows.
	assign arrayWrEn = latchLoaded
		&& (state_r == S_ERASE || state_r == S_WRITE)
		&& (flash_space_select_r != `FPC_MODE_SEC);

	fpc_flash_array #(
		.PW     (PW),
		.BW     (BW)
	) uArray (
		.ref_clk (ref_clk),
		.rdAddr  (codeAddr[PW+BW-1:0]),
		.rdXrow  (rdXrow),
		.rdData  (arrayData),
		.wrEn    (arrayWrEn),
		.wrXrow  (flash_space_select_r == `FPC_MODE_XROW),
		.wrAddr  ({pageSel_r, walkIdx_r}),
		.wrData  ((state_r == S_ERASE) ? 8'hff : latchData)
	);

	// ----------------------------------------------------------------
	// Security byte
	// ----------------------------------------------------------------
	// Software may only touch speed and boot bits; the rest need the
	// parallel programmer. A forbidden oscillator code keeps the old one.
	assign secMerged = {latchData[`FPC_SEC_SPEED],
		latchData[`FPC_SEC_BOOT],
		nonvolatile_security_byte_r[5:0]};

	// The cells keep their contents through rst, so a new boot or speed
	// choice is seen at the next reset. Power-up holds the default byte.
	initial begin
		nonvolatile_security_byte_r = `FPC_SEC_RESET;
	end

	always @(posedge ref_clk) begin
		if (ppSecWrite) begin
			nonvolatile_security_byte_r[7:6] <= ppSecData[7:6];
			if (ppSecData[`FPC_SEC_OSC_HI:`FPC_SEC_OSC_LO] != `FPC_OSC_BAD) begin
				nonvolatile_security_byte_r[5:4] <= ppSecData[5:4];
			end
			nonvolatile_security_byte_r[3] <= 1'b0;
			nonvolatile_security_byte_r[2:0] <= ppSecData[2:0];
		end else if (state_r == S_WRITE && walkIdx_r == {BW{1'b0}}
			&& latchLoaded
			&& flash_space_select_r == `FPC_MODE_SEC) begin
			nonvolatile_security_byte_r <= secMerged;
		end
	end

	// Boot target and speed are taken once after reset release, so a
	// change only takes effect on the next reset.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bootTaken_r           <= 1'b0;
			bootVector_r          <= `FPC_BOOT_LOADER;
			double_speed_select_r <= 1'b0;
		end else if (!bootTaken_r) begin
			bootTaken_r <= 1'b1;
			bootVector_r <= nonvolatile_security_byte_r[`FPC_SEC_BOOT]
				? `FPC_BOOT_USER : `FPC_BOOT_LOADER;
			double_speed_select_r <=
				!nonvolatile_security_byte_r[`FPC_SEC_SPEED];
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			oscillator_range_r <= 2'h3;
			lock_level_bits_r  <= 3'h0;
		end else begin
			oscillator_range_r <= nonvolatile_security_byte_r
				[`FPC_SEC_OSC_HI:`FPC_SEC_OSC_LO];
			lock_level_bits_r  <= nonvolatile_security_byte_r
				[`FPC_SEC_LOCK_HI:`FPC_SEC_LOCK_LO];
		end
	end

	// ----------------------------------------------------------------
	// Code fetch
	// ----------------------------------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			eaMeta_r <= 1'b1;
			eaSync_r <= 1'b1;
		end else begin
			eaMeta_r <= external_access_pin;
			eaSync_r <= eaMeta_r;
		end
	end

	assign rdXrow = (flash_space_select_r == `FPC_MODE_XROW)
		&& inXrow(codeAddr);

	// A fetch is answered every cycle; the array has no busy stall here
	// because the CPU is idled for the whole programming span.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			codeData_r      <= 8'h00;
			externalFetch_r <= 1'b0;
		end else begin
			externalFetch_r <= !eaSync_r || (codeAddr[15] && !rdXrow)
				? (flash_space_select_r != `FPC_MODE_SEC) : 1'b0;
			if (flash_space_select_r == `FPC_MODE_SEC) begin
				codeData_r <= nonvolatile_security_byte_r;
			end else if (!eaSync_r || (codeAddr[15] && !rdXrow)) begin
				codeData_r <= 8'h00;
			end else begin
				codeData_r <= arrayData;
			end
		end
	end

endmodule

//--- testbench/fpc_flash_program_control_monitor.sv
`timescale 1ns/100ps

// ------------------------------------------------
// Port checks of the flash sequencer.
// ------------------------------------------------
module fpc_flash_program_control_monitor #(
	parameter PROG_CYCLES = 300
) (
	input wire logic	ref_clk,
	input wire logic	rst,
	input wire logic [7:0]	sfrAddr,
	input wire logic	sfrWrite,
	input wire logic	sfrRead,
	input wire logic [7:0]	sfrWdata,
	input wire logic [7:0]	sfrRdata_r,
	input wire logic	latch_space_map_r,
	input wire logic [7:0]	codeData_r,
	input wire logic	externalFetch_r,
	input wire logic	ppSecWrite,
	input wire logic [7:0]	ppSecData,
	input wire logic	cpuIdleReq_r,
	input wire logic [1:0]	oscillator_range_r,
	input wire logic [7:0]	nonvolatile_security_byte_r
);
	logic		armed_r;
	logic [31:0]	busyCnt_r;
	wire		fcWr = sfrWrite && sfrAddr == 8'hd1;
	wire		launchOk = fcWr && sfrWdata[7:4] == 4'ha && armed_r
			&& sfrWdata[2:1] != 2'h3 && !cpuIdleReq_r;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Shadow of the unlock step, so a stray write between 5 and A is seen.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			armed_r <= 1'h0;
			busyCnt_r <= 32'h0;
		end else begin
			if (fcWr)
				armed_r <= sfrWdata[7:4] == 4'h5;
			busyCnt_r <= cpuIdleReq_r ? busyCnt_r + 32'h1 : 32'h0;
		end
	end

	AST_LAUNCH: assert property (launchOk |=> cpuIdleReq_r)
		else $error("launch did not start programming");
	AST_NOLAUNCH: assert property (fcWr && !launchOk && !cpuIdleReq_r
		|=> !cpuIdleReq_r) else $error("programming started unasked");
	AST_BUSYLEN: assert property ($fell(cpuIdleReq_r)
		|-> busyCnt_r == PROG_CYCLES + 1) else $error("busy length wrong");
	AST_RDSTAT: assert property (sfrRead && sfrAddr == 8'hd1
		|=> sfrRdata_r[0] == $past(cpuIdleReq_r)
		&& sfrRdata_r[3] == $past(latch_space_map_r))
		else $error("control read wrong");
	AST_MAP: assert property (fcWr
		|=> latch_space_map_r == $past(sfrWdata[3]))
		else $error("map bit not taken");
	AST_OSC: assert property (ppSecWrite
		|=> nonvolatile_security_byte_r[5:4] == ($past(ppSecData[5:4])
		== 2'h0 ? $past(nonvolatile_security_byte_r[5:4])
		: $past(ppSecData[5:4]))
		##1 oscillator_range_r == $past(nonvolatile_security_byte_r[5:4]))
		else $error("oscillator range wrong");
	AST_PPBITS: assert property (ppSecWrite
		|=> nonvolatile_security_byte_r[7:6] == $past(ppSecData[7:6])
		&& nonvolatile_security_byte_r[3:0] == {1'h0, $past(ppSecData[2:0])})
		else $error("security bits wrong");
	AST_EXT: assert property (externalFetch_r
		|-> codeData_r == 8'h00) else $error("external fetch data");

	COV_LAUNCH: cover property (launchOk);
	COV_DONE: cover property ($fell(cpuIdleReq_r));
	COV_EXT: cover property (externalFetch_r);
endmodule

bind fpc_flash_program_control fpc_flash_program_control_monitor #(
	.PROG_CYCLES(PROG_CYCLES)
) mon_u (
	.ref_clk(ref_clk), .rst(rst), .sfrAddr(sfrAddr),
	.sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
	.sfrRdata_r(sfrRdata_r), .latch_space_map_r(latch_space_map_r),
	.codeData_r(codeData_r), .externalFetch_r(externalFetch_r),
	.ppSecWrite(ppSecWrite), .ppSecData(ppSecData),
	.cpuIdleReq_r(cpuIdleReq_r), .oscillator_range_r(oscillator_range_r),
	.nonvolatile_security_byte_r(nonvolatile_security_byte_r)
);

//--- testbench/fpc_flash_program_control_bench.sv
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end

// ------------------------------------------------
// Bench for the flash sequencer.
// ------------------------------------------------
module fpc_flash_program_control_bench;
	// Short program time keeps the run small; expectations follow it.
	localparam PC = 300;
	logic		ref_clk = 0;
	logic		rst = 1;
	logic [7:0]	sfrAddr = 8'hd1;
	logic		sfrWrite = 0;
	logic		sfrRead = 0;
	logic [7:0]	sfrWdata = 8'h00;
	logic [15:0]	xdataAddr = 16'h0000;
	logic		xdataWrite = 0;
	logic [7:0]	xdataWdata = 8'h00;
	logic [15:0]	codeAddr = 16'h0000;
	logic		extPin = 1;
	logic		ppSecWrite = 0;
	logic [7:0]	ppSecData = 8'h00;
	wire [7:0]	sfrRdata, codeData, secByte;
	wire		mapOn, extFetch, idle, speed;
	wire [15:0]	bootVec;
	wire [1:0]	oscRange;
	wire [2:0]	lockBits;
	int		errors = 0;
	int		check_count = 0;
	int		cycles = 0;
	int		n;
	int		i;

	fpc_flash_program_control #(.PROG_CYCLES(PC)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .sfrAddr(sfrAddr),
		.sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
		.sfrRdata_r(sfrRdata), .xdataAddr(xdataAddr),
		.xdataWrite(xdataWrite), .xdataWdata(xdataWdata),
		.latch_space_map_r(mapOn), .codeAddr(codeAddr),
		.codeData_r(codeData), .externalFetch_r(extFetch),
		.external_access_pin(extPin), .ppSecWrite(ppSecWrite),
		.ppSecData(ppSecData), .cpuIdleReq_r(idle),
		.double_speed_select_r(speed), .bootVector_r(bootVec),
		.oscillator_range_r(oscRange), .lock_level_bits_r(lockBits),
		.nonvolatile_security_byte_r(secByte)
	);

	always #4 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			print_verdict();
		end
	end

	task print_verdict;
		if (errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task tick;
		@(posedge ref_clk);
		#1;
	endtask

	task wr(input [7:0] d);
		sfrAddr = 8'hd1;
		sfrWdata = d;
		sfrWrite = 1;
		tick;
		sfrWrite = 0;
		tick;
	endtask

	task rd(input [7:0] a, input [7:0] e, input [7:0] m);
		sfrAddr = a;
		sfrRead = 1;
		tick;
		sfrRead = 0;
		`CHK(sfrRdata & m, e)
		tick;
	endtask

	task xw(input [15:0] a, input [7:0] d);
		xdataAddr = a;
		xdataWdata = d;
		xdataWrite = 1;
		tick;
		xdataWrite = 0;
		tick;
	endtask

	task fe(input [15:0] a, input [7:0] e, input x);
		codeAddr = a;
		tick;
		`CHK(codeData, e)
		`CHK(extFetch, x)
	endtask

	task pp(input [7:0] d);
		ppSecData = d;
		ppSecWrite = 1;
		tick;
		ppSecWrite = 0;
		tick;
	endtask

	// Launch with the low nibble m, then time the busy window.
	task prog(input [3:0] m);
		wr({4'h5, m});
		wr({4'ha, m});
		`CHK(idle, 1'h1)
		rd(8'hd1, 8'h01, 8'h01);
		n = 0;
		while (idle === 1'h1 && n < 2 * PC) begin
			tick;
			n++;
		end
		`CHK(n, PC - 2)
		rd(8'hd1, 8'h00, 8'h01);
	endtask

	initial begin
		repeat (3) @(posedge ref_clk);
		#1 rst = 0;
		tick;
		rd(8'hd1, 8'h00, 8'hff);
		rd(8'h80, 8'h00, 8'hff);
		`CHK(bootVec, 16'hf400)
		`CHK(speed, 1'h0)
		`CHK(secByte, 8'hb0)
		`CHK(lockBits, 3'h0)
		wr(8'h09);
		rd(8'hd1, 8'h08, 8'hff);
		`CHK(mapOn, 1'h1)
		wr(8'ha0);
		`CHK(idle, 1'h0)
		`CHK(mapOn, 1'h0)
		wr(8'h50);
		wr(8'h08);
		wr(8'ha8);
		`CHK(idle, 1'h0)
		wr(8'h5e);
		wr(8'hae);
		`CHK(idle, 1'h0)
		wr(8'ha8);
		`CHK(idle, 1'h0)
		xw(16'h7fff, 8'h3c);
		prog(4'h8);
		xw(16'h7fff, 8'hc3);
		prog(4'h8);
		xw(16'h0005, 8'h96);
		xw(16'h0102, 8'h69);
		prog(4'h8);
		wr(8'h00);
		fe(16'h7fff, 8'hc3, 1'h0);
		fe(16'h0105, 8'h96, 1'h0);
		fe(16'h0102, 8'h69, 1'h0);
		fe(16'h8000, 8'h00, 1'h1);
		wr(8'h0a);
		xw(16'hff83, 8'h77);
		prog(4'ha);
		wr(8'h02);
		fe(16'hff83, 8'h77, 1'h0);
		wr(8'h0c);
		xw(16'h0000, 8'h40);
		prog(4'hc);
		`CHK(secByte, 8'h70)
		wr(8'h04);
		fe(16'h1234, 8'h70, 1'h0);
		pp(8'h9d);
		`CHK(secByte, 8'h95)
		`CHK(lockBits, 3'h5)
		pp(8'hc2);
		`CHK(secByte, 8'hd2)
		for (i = 1; i < 4; i++) begin
			pp({2'h1, i[1:0], 4'h0});
			`CHK(oscRange, i[1:0])
		end
		wr(8'h00);
		extPin = 0;
		tick;
		tick;
		fe(16'h0010, 8'h00, 1'h1);
		extPin = 1;
		tick;
		tick;
		fe(16'h7fff, 8'hc3, 1'h0);
		wr(8'h08);
		rst = 1;
		tick;
		rst = 0;
		tick;
		rd(8'hd1, 8'h00, 8'hff);
		`CHK(secByte, 8'h70)
		`CHK(bootVec, 16'h0000)
		`CHK(speed, 1'h1)
		print_verdict();
	end
endmodule
